/* prox_irq_pkg.sv */
// Constants for the proximity configuration and interrupt block.
// Behaviour
// - Gain level bits 6:4, 000 least sensitive
// - Frequency codes 010..101 map 64..150 kHz
// - Sense select routes none, aux1, aux2, X, Y
// - Guard select routes none, aux3, X, Y
// - Boost field 5:3: 100 on, 110 off
// - One mask bit per source, bit3 resets 1
// - Source 7 on motor short rising edge
// - Source 6 on near flag rising edge
// - Source 5: far edge or prox conversion end
// - Source 4 on compensation pending falling edge
// - Source 3: pen down or touch conversion end
// - Source 2 on pen down falling edge
// - Source 1 on selected thermal warning edge
// - Source 0 on selected thermal alarm edge
// - Status 7 shows live motor short
// - Status 6 latches reset, read clears
// - Near flag frozen while pen down, cleared when sense select is none
// - Writing 1 requests compensation until done
// - Conversion flag high while converting
package prox_irq_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_GAIN_FREQ = 8'h1D;
	localparam logic [7:0] ADDR_ROUTING = 8'h1E;
	localparam logic [7:0] ADDR_BOOST = 8'h1F;
	localparam logic [7:0] ADDR_TRIM_A = 8'h20;
	localparam logic [7:0] ADDR_TRIM_B = 8'h21;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h22;
	localparam logic [7:0] ADDR_IRQ_SRC = 8'h23;
	localparam logic [7:0] ADDR_STATUS = 8'h24;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_GAIN_FREQ = 8'h00;
	localparam logic [7:0] RST_ROUTING = 8'h00;
	localparam logic [7:0] RST_BOOST = 8'h00;
	localparam logic [7:0] RST_TRIM_A = 8'h01;
	localparam logic [7:0] RST_TRIM_B = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h08;
	localparam logic [7:0] RST_IRQ_SRC = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int GAIN_LSB = 4;
	localparam int FREQ_LSB = 1;
	localparam int SENSE_LSB = 4;
	localparam int GUARD_LSB = 0;
	localparam int BOOST_LSB = 3;
	localparam int STAT_MOTOR = 7;
	localparam int STAT_RESET = 6;
	localparam int STAT_NEAR = 5;
	localparam int STAT_COMP = 4;
	localparam int STAT_CONV = 3;
	localparam int STAT_PEN = 2;
	localparam int STAT_WARN = 1;
	localparam int STAT_ALARM = 0;
	localparam logic [7:0] MASK_GAIN_FREQ = 8'h7E;
	localparam logic [7:0] MASK_BOOST = 8'h3F;

	// Positions in the watched level vector
	localparam int LV_MOTOR = 6;
	localparam int LV_NEAR = 5;
	localparam int LV_CONV = 4;
	localparam int LV_COMP = 3;
	localparam int LV_PEN = 2;
	localparam int LV_WARN = 1;
	localparam int LV_ALARM = 0;
	localparam int LV_WIDTH = 7;

	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [2:0] FREQ_64K = 3'h2;
	localparam logic [2:0] FREQ_90K = 3'h3;
	localparam logic [2:0] FREQ_112K = 3'h4;
	localparam logic [2:0] FREQ_150K = 3'h5;
	localparam logic [7:0] KHZ_64 = 8'h40;
	localparam logic [7:0] KHZ_90 = 8'h5A;
	localparam logic [7:0] KHZ_112 = 8'h70;
	localparam logic [7:0] KHZ_150 = 8'h96;
	localparam logic [3:0] SENSE_NONE = 4'h0;
	localparam logic [3:0] SENSE_AUX1 = 4'h1;
	localparam logic [3:0] SENSE_AUX2 = 4'h2;
	localparam logic [3:0] ELEC_X = 4'h8;
	localparam logic [3:0] ELEC_Y = 4'h9;
	localparam logic [3:0] GUARD_AUX3 = 4'h3;
	localparam logic [2:0] BOOST_ON = 3'h4;
	localparam logic [2:0] BOOST_OFF = 3'h6;

endpackage

/* edge_detect.sv */
// Registered rising and falling edge detector for a vector of levels.
`timescale 1ns/1ps
module edge_detect
	import prox_irq_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic sys_clk, // Clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic [W-1:0] level, // Levels to watch
	output logic [W-1:0] rise, // High in the cycle a level goes 0 to 1
	output logic [W-1:0] fall // High in the cycle a level goes 1 to 0
);

	logic [W-1:0] prev_reg;
	logic [W-1:0] prev_next;

	always_comb begin
		prev_next = level;
		rise = level & ~prev_reg;
		fall = ~level & prev_reg;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= prev_next;
		end
	end

endmodule

/* prox_irq_config.sv */
// Proximity configuration registers, status register and interrupt sources.
`timescale 1ns/1ps
module prox_irq_config
	import prox_irq_pkg::*;
(
	input wire logic sys_clk, // 250 MHz clock
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic [7:0] regAddr, // Register address from serial front end
	input wire logic regWrEn, // Write strobe, one cycle
	input wire logic [7:0] regWrData, // Write data
	input wire logic regRdEn, // Read strobe, one cycle
	output logic [7:0] regRdData, // Read data, valid cycle after strobe
	input wire logic motorShortIn, // Motor driver short present
	input wire logic nearObjectIn, // Proximity detector says close
	input wire logic convRunningIn, // Touch or proximity conversion running
	input wire logic convIsProxIn, // Running conversion is a proximity one
	input wire logic compDoneIn, // Requested compensation finished, pulse
	input wire logic penDownIn, // Pen touching
	input wire logic thermalWarnIn, // Above warning threshold
	input wire logic thermalAlarmIn, // Above alarm threshold
	input wire logic farOrDoneSelect, // 1: source 5 on prox conversion end
	input wire logic penDetectOperation, // Pen-detect operating mode
	input wire logic warnEdgeSelect, // 1: rising warning edge, 0: falling
	input wire logic alarmEdgeSelect, // 1: rising alarm edge, 0: falling
	output logic irqOut, // Interrupt request, active high
	output logic [2:0] proxGainLevel, // Sensitivity step 0..7
	output logic [2:0] proxOscFreqSel, // Oscillator frequency code
	output logic [7:0] proxOscKhz, // Decoded frequency, 0 when reserved
	output logic [3:0] senseElectrodeSel, // Sense routing code
	output logic [3:0] senseRoute, // One-hot {Y, X, aux2, aux1/wiper}
	output logic [3:0] guardElectrodeSel, // Guard routing code
	output logic [2:0] guardRoute, // One-hot {Y, X, aux3}
	output logic [2:0] gainBoostSel, // Boost field
	output logic boostOn, // Higher sensitivity boost active
	output logic compRequest // Compensation pending
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [7:0] gainFreq_reg, gainFreq_next;
	logic [7:0] routing_reg, routing_next;
	logic [7:0] boost_reg, boost_next;
	logic [7:0] trimA_reg, trimA_next;
	logic [7:0] irqMask_reg, irqMask_next;
	logic [7:0] irqSrc_reg, irqSrc_next;
	logic resetSeen_reg, resetSeen_next;
	logic nearFlag_reg, nearFlag_next;
	logic compPending_reg, compPending_next;
	logic convProx_reg, convProx_next;
	logic [7:0] rdData_reg, rdData_next;
	logic irq_reg, irq_next;
	logic [7:0] khz_reg, khz_next;
	logic [3:0] senseRoute_reg, senseRoute_next;
	logic [2:0] guardRoute_reg, guardRoute_next;
	logic boostOn_reg, boostOn_next;
	logic [LV_WIDTH-1:0] levels, rise, fall;
	logic [7:0] events;
	logic [7:0] statusView;
	logic wrHit, rdSrc, rdStat;

	function automatic logic pickEdge(input logic r, input logic f, input logic selRise);
		pickEdge = selRise ? r : f;
	endfunction

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	always_comb begin
		levels = '0;
		levels[LV_MOTOR] = motorShortIn;
		levels[LV_NEAR] = nearFlag_reg;
		levels[LV_CONV] = convRunningIn;
		levels[LV_COMP] = compPending_reg;
		levels[LV_PEN] = penDownIn;
		levels[LV_WARN] = thermalWarnIn;
		levels[LV_ALARM] = thermalAlarmIn;
	end

	edge_detect #(
		.W(LV_WIDTH)
	) u_edges (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.level(levels),
		.rise(rise),
		.fall(fall)
	);

	always_comb begin
		events[7] = rise[LV_MOTOR];
		events[6] = rise[LV_NEAR];
		// Conversion kind is remembered while running, the edge comes after it ends
		events[5] = farOrDoneSelect ? (fall[LV_CONV] & convProx_reg) : fall[LV_NEAR];
		events[4] = fall[LV_COMP];
		events[3] = penDetectOperation ? rise[LV_PEN] : (fall[LV_CONV] & ~convProx_reg);
		events[2] = fall[LV_PEN];
		events[1] = pickEdge(rise[LV_WARN], fall[LV_WARN], warnEdgeSelect);
		events[0] = pickEdge(rise[LV_ALARM], fall[LV_ALARM], alarmEdgeSelect);
	end

	// ----------------------------------------
	// Register file and flags
	// ----------------------------------------
	always_comb begin
		wrHit = regWrEn;
		rdSrc = regRdEn && (regAddr == ADDR_IRQ_SRC);
		rdStat = regRdEn && (regAddr == ADDR_STATUS);
		statusView = {motorShortIn, resetSeen_reg, nearFlag_reg, compPending_reg,
			convRunningIn, penDownIn, thermalWarnIn, thermalAlarmIn};
		gainFreq_next = gainFreq_reg;
		routing_next = routing_reg;
		boost_next = boost_reg;
		trimA_next = trimA_reg;
		irqMask_next = irqMask_reg;
		compPending_next = compPending_reg;
		if (wrHit && regAddr == ADDR_GAIN_FREQ) begin
			gainFreq_next = regWrData & MASK_GAIN_FREQ;
		end else if (wrHit && regAddr == ADDR_ROUTING) begin
			routing_next = regWrData;
		end else if (wrHit && regAddr == ADDR_BOOST) begin
			boost_next = regWrData & MASK_BOOST;
		end else if (wrHit && regAddr == ADDR_TRIM_A) begin
			trimA_next = regWrData;
		end else if (wrHit && regAddr == ADDR_IRQ_MASK) begin
			irqMask_next = regWrData;
		end
		// Completion clears the request, a new request in the same cycle wins
		if (compDoneIn) begin
			compPending_next = 1'b0;
		end
		if (wrHit && regAddr == ADDR_STATUS && regWrData[STAT_COMP]) begin
			compPending_next = 1'b1;
		end
		// Reads clear, but an event in the same cycle still lands
		irqSrc_next = (rdSrc ? 8'h00 : irqSrc_reg) | events;
		resetSeen_next = rdStat ? 1'b0 : resetSeen_reg;
		if (senseElectrodeSel == SENSE_NONE) begin
			nearFlag_next = 1'b0;
		end else if (penDownIn) begin
			nearFlag_next = nearFlag_reg;
		end else begin
			nearFlag_next = nearObjectIn;
		end
		convProx_next = convRunningIn ? convIsProxIn : convProx_reg;
		rdData_next = rdData_reg;
		if (regRdEn) begin
			if (regAddr == ADDR_GAIN_FREQ) begin
				rdData_next = gainFreq_reg;
			end else if (regAddr == ADDR_ROUTING) begin
				rdData_next = routing_reg;
			end else if (regAddr == ADDR_BOOST) begin
				rdData_next = boost_reg;
			end else if (regAddr == ADDR_TRIM_A) begin
				rdData_next = trimA_reg;
			end else if (regAddr == ADDR_TRIM_B) begin
				rdData_next = RST_TRIM_B;
			end else if (regAddr == ADDR_IRQ_MASK) begin
				rdData_next = irqMask_reg;
			end else if (regAddr == ADDR_IRQ_SRC) begin
				rdData_next = irqSrc_reg;
			end else if (regAddr == ADDR_STATUS) begin
				rdData_next = statusView;
			end else begin
				rdData_next = 8'h00;
			end
		end
		// Built from next values so the pin tracks the registers exactly
		irq_next = |(irqSrc_next & irqMask_next);
	end

	// ----------------------------------------
	// Decoded configuration
	// ----------------------------------------
	always_comb begin
		case (gainFreq_next[FREQ_LSB +: 3])
			FREQ_64K: khz_next = KHZ_64;
			FREQ_90K: khz_next = KHZ_90;
			FREQ_112K: khz_next = KHZ_112;
			FREQ_150K: khz_next = KHZ_150;
			default: khz_next = 8'h00;
		endcase
		case (routing_next[SENSE_LSB +: 4])
			SENSE_AUX1: senseRoute_next = 4'h1;
			SENSE_AUX2: senseRoute_next = 4'h2;
			ELEC_X: senseRoute_next = 4'h4;
			ELEC_Y: senseRoute_next = 4'h8;
			default: senseRoute_next = 4'h0;
		endcase
		case (routing_next[GUARD_LSB +: 4])
			GUARD_AUX3: guardRoute_next = 3'h1;
			ELEC_X: guardRoute_next = 3'h2;
			ELEC_Y: guardRoute_next = 3'h4;
			default: guardRoute_next = 3'h0;
		endcase
		// Reserved boost codes leave boost off; host should use the off code
		boostOn_next = (boost_next[BOOST_LSB +: 3] == BOOST_ON);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			gainFreq_reg <= RST_GAIN_FREQ;
			routing_reg <= RST_ROUTING;
			boost_reg <= RST_BOOST;
			trimA_reg <= RST_TRIM_A;
			irqMask_reg <= RST_IRQ_MASK;
			irqSrc_reg <= RST_IRQ_SRC;
			resetSeen_reg <= 1'b1;
			nearFlag_reg <= 1'b0;
			compPending_reg <= 1'b0;
			convProx_reg <= 1'b0;
			rdData_reg <= 8'h00;
			irq_reg <= 1'b0;
			khz_reg <= 8'h00;
			senseRoute_reg <= 4'h0;
			guardRoute_reg <= 3'h0;
			boostOn_reg <= 1'b0;
		end else begin
			gainFreq_reg <= gainFreq_next;
			routing_reg <= routing_next;
			boost_reg <= boost_next;
			trimA_reg <= trimA_next;
			irqMask_reg <= irqMask_next;
			irqSrc_reg <= irqSrc_next;
			resetSeen_reg <= resetSeen_next;
			nearFlag_reg <= nearFlag_next;
			compPending_reg <= compPending_next;
			convProx_reg <= convProx_next;
			rdData_reg <= rdData_next;
			irq_reg <= irq_next;
			khz_reg <= khz_next;
			senseRoute_reg <= senseRoute_next;
			guardRoute_reg <= guardRoute_next;
			boostOn_reg <= boostOn_next;
		end
	end

	always_comb begin
		regRdData = rdData_reg;
		irqOut = irq_reg;
		proxGainLevel = gainFreq_reg[GAIN_LSB +: 3];
		proxOscFreqSel = gainFreq_reg[FREQ_LSB +: 3];
		proxOscKhz = khz_reg;
		senseElectrodeSel = routing_reg[SENSE_LSB +: 4];
		senseRoute = senseRoute_reg;
		guardElectrodeSel = routing_reg[GUARD_LSB +: 4];
		guardRoute = guardRoute_reg;
		gainBoostSel = boost_reg[BOOST_LSB +: 3];
		boostOn = boostOn_reg;
		compRequest = compPending_reg;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_motorRise;
		!motorShortIn ##1 motorShortIn;
	endsequence
	sequence s_penLift;
		penDownIn ##1 !penDownIn;
	endsequence
	sequence s_srcRead;
		regRdEn && regAddr == ADDR_IRQ_SRC;
	endsequence

	a_gain_write_lands: assert property (regWrEn && regAddr == ADDR_GAIN_FREQ |=>
		{1'b0, proxGainLevel, 4'h0} == ($past(regWrData) & 8'h70))
		else $error("gain level not taken from write");
	a_freq_decode_150: assert property (proxOscFreqSel == 3'h5 |-> proxOscKhz == 8'h96)
		else $error("150 kHz code not decoded");
	a_sense_route_x: assert property ((senseElectrodeSel == 4'h8) == senseRoute[2])
		else $error("sense X routing wrong");
	a_guard_route_y: assert property ((guardElectrodeSel == 4'h9) == guardRoute[2])
		else $error("guard Y routing wrong");
	a_boost_code_on: assert property (boostOn == (gainBoostSel == 3'h4))
		else $error("boost state does not match code");
	a_motor_edge_sets: assert property (s_motorRise |=> irqSrc_reg[7])
		else $error("motor short edge missed");
	a_pen_lift_sets: assert property (s_penLift |=> irqSrc_reg[2])
		else $error("pen lift edge missed");
	a_src_read_clear: assert property (s_srcRead |=>
		regRdData == $past(irqSrc_reg) && irqSrc_reg == $past(events))
		else $error("source read did not return and clear");
	a_reset_seen_clear: assert property (regRdEn && regAddr == ADDR_STATUS |=>
		!resetSeen_reg)
		else $error("reset flag not cleared by read");
	a_irq_gating: assert property (irqOut == |(irqSrc_reg & irqMask_reg))
		else $error("interrupt output not gated by mask");
	a_comp_request_set: assert property (regWrEn && regAddr == ADDR_STATUS && regWrData[4]
		|=> compRequest)
		else $error("compensation request lost");
	a_near_frozen_pen: assert property (penDownIn && senseElectrodeSel != 4'h0
		|=> nearFlag_reg == $past(nearFlag_reg))
		else $error("near flag moved while pen down");

endmodule

/* host_model.sv */
// Host processor model that drives the register port.
`timescale 1ns/1ps
module host_model
	import prox_irq_pkg::*;
(
	input wire logic sys_clk, // Clock
	output logic [7:0] regAddr, // Register address
	output logic regWrEn, // Write strobe
	output logic [7:0] regWrData, // Write data
	output logic regRdEn, // Read strobe
	input wire logic [7:0] regRdData // Read data
);
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end

	// Idle bus shows inverted values, so stale data cannot pass as fresh
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge sys_clk);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge sys_clk);
		regRdEn = 1'b0;
		regAddr = ~a;
		d = regRdData;
	endtask

	// Start-up writes: trim A to its required value, boost off
	task automatic init_trims();
		wr(ADDR_TRIM_A, 8'h81);
		wr(ADDR_BOOST, 8'h34);
	endtask
endmodule

/* testbench.sv */
// Self-checking bench for the proximity configuration and interrupt block.
`timescale 1ns/1ps
module testbench
	import prox_irq_pkg::*;
;
	logic sys_clk, reset_n, regWrEn, regRdEn, irqOut, boostOn, compRequest;
	logic [7:0] regAddr, regWrData, regRdData, proxOscKhz, curMask, bitV;
	logic motorShortIn, nearObjectIn, convRunningIn, convIsProxIn, compDoneIn;
	logic penDownIn, thermalWarnIn, thermalAlarmIn, farOrDoneSelect;
	logic penDetectOperation, warnEdgeSelect, alarmEdgeSelect;
	logic [2:0] proxGainLevel, proxOscFreqSel, gainBoostSel, guardRoute, g;
	logic [3:0] senseElectrodeSel, senseRoute, guardElectrodeSel;
	int bad_count, compares;

	prox_irq_config dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.motorShortIn(motorShortIn), .nearObjectIn(nearObjectIn), .convRunningIn(convRunningIn),
		.convIsProxIn(convIsProxIn), .compDoneIn(compDoneIn), .penDownIn(penDownIn),
		.thermalWarnIn(thermalWarnIn), .thermalAlarmIn(thermalAlarmIn),
		.farOrDoneSelect(farOrDoneSelect), .penDetectOperation(penDetectOperation),
		.warnEdgeSelect(warnEdgeSelect), .alarmEdgeSelect(alarmEdgeSelect), .irqOut(irqOut),
		.proxGainLevel(proxGainLevel), .proxOscFreqSel(proxOscFreqSel), .proxOscKhz(proxOscKhz),
		.senseElectrodeSel(senseElectrodeSel), .senseRoute(senseRoute),
		.guardElectrodeSel(guardElectrodeSel), .guardRoute(guardRoute),
		.gainBoostSel(gainBoostSel), .boostOn(boostOn), .compRequest(compRequest));

	host_model hostU (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] khz(input logic [2:0] c);
		case (c)
			FREQ_64K: return KHZ_64;
			FREQ_90K: return KHZ_90;
			FREQ_112K: return KHZ_112;
			FREQ_150K: return KHZ_150;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] route(input logic [3:0] c, input logic guard);
		case (c)
			4'h1: return guard ? 8'h00 : 8'h01;
			4'h2: return guard ? 8'h00 : 8'h02;
			4'h3: return guard ? 8'h01 : 8'h00;
			4'h8: return guard ? 8'h02 : 8'h04;
			4'h9: return guard ? 8'h04 : 8'h08;
			default: return 8'h00;
		endcase
	endfunction

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
		logic [7:0] d;
		hostU.rd(a, d);
		check(name, exp, d);
	endtask

	// Let the edge, the source latch and the interrupt settle, then read and clear
	task automatic srcchk(input logic [7:0] exp);
		repeat (5) @(negedge sys_clk);
		check("irqOut", {7'h00, |(exp & curMask)}, {7'h00, irqOut});
		rdchk(ADDR_IRQ_SRC, exp, "source");
		check("irqOut cleared", 8'h00, {7'h00, irqOut});
	endtask

	task automatic conv(input logic prox);
		convIsProxIn = prox;
		convRunningIn = 1'b1;
		repeat (3) @(negedge sys_clk);
		convRunningIn = 1'b0;
	endtask

	task automatic therm(input int k, input logic sel, input logic lvl);
		if (k == 0) begin
			warnEdgeSelect = sel;
			thermalWarnIn = lvl;
		end else begin
			alarmEdgeSelect = sel;
			thermalAlarmIn = lvl;
		end
	endtask

	initial begin
		#100000;
		bad_count++;
		conclude();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{motorShortIn, nearObjectIn, convRunningIn, convIsProxIn} = 4'h0;
		{compDoneIn, penDownIn, thermalWarnIn, thermalAlarmIn} = 4'h0;
		{farOrDoneSelect, penDetectOperation, warnEdgeSelect, alarmEdgeSelect} = 4'h0;
		reset_n = 1'b0;
		bad_count = 0;
		compares = 0;
		curMask = RST_IRQ_MASK;
		void'($urandom(53));
		repeat (6) @(negedge sys_clk);
		reset_n = 1'b1;
		rdchk(ADDR_STATUS, 8'h40, "status");
		rdchk(ADDR_STATUS, 8'h00, "status");
		rdchk(ADDR_IRQ_MASK, 8'h08, "mask");
		rdchk(ADDR_TRIM_A, 8'h01, "trimA");
		rdchk(ADDR_IRQ_SRC, 8'h00, "source");
		for (int i = 0; i < 8; i++) begin
			g = 3'($urandom);
			hostU.wr(ADDR_GAIN_FREQ, {1'b1, g, i[2:0], 1'b1});
			rdchk(ADDR_GAIN_FREQ, {1'b0, g, i[2:0], 1'b0}, "gainFreq");
			check("gain", {5'h00, g}, {5'h00, proxGainLevel});
			check("khz", khz(i[2:0]), proxOscKhz);
			check("freqSel", {5'h00, i[2:0]}, {5'h00, proxOscFreqSel});
			hostU.wr(ADDR_BOOST, {2'b11, i[2:0], 3'h4});
			check("boostOn", {7'h00, i == 4}, {7'h00, boostOn});
			check("boost", {5'h00, i[2:0]}, {5'h00, gainBoostSel});
		end
		// Boost must be off before the touchscreen is made the sensor
		hostU.init_trims();
		for (int i = 0; i < 16; i++) begin
			hostU.wr(ADDR_ROUTING, {i[3:0], i[3:0]});
			check("sense", route(i[3:0], 1'b0), {4'h0, senseRoute});
			check("guard", route(i[3:0], 1'b1), {5'h00, guardRoute});
			check("senseSel", {4'h0, i[3:0]}, {4'h0, senseElectrodeSel});
			check("guardSel", {4'h0, i[3:0]}, {4'h0, guardElectrodeSel});
		end
		hostU.wr(ADDR_ROUTING, 8'h89);
		rdchk(ADDR_ROUTING, 8'h89, "routing");
		rdchk(ADDR_TRIM_A, 8'h81, "trimA");
		rdchk(ADDR_BOOST, 8'h34, "boost");
		hostU.wr(ADDR_TRIM_B, 8'hFF);
		rdchk(ADDR_TRIM_B, 8'h00, "trimB");
		rdchk(8'h40, 8'h00, "unmapped");
		curMask = 8'hFF;
		hostU.wr(ADDR_IRQ_MASK, curMask);
		motorShortIn = 1'b1;
		srcchk(8'h80);
		rdchk(ADDR_STATUS, 8'h80, "status");
		motorShortIn = 1'b0;
		srcchk(8'h00);
		rdchk(ADDR_STATUS, 8'h00, "status");
		nearObjectIn = 1'b1;
		srcchk(8'h40);
		nearObjectIn = 1'b0;
		srcchk(8'h20);
		farOrDoneSelect = 1'b1;
		nearObjectIn = 1'b1;
		srcchk(8'h40);
		nearObjectIn = 1'b0;
		srcchk(8'h00);
		conv(1'b1);
		srcchk(8'h20);
		conv(1'b0);
		srcchk(8'h08);
		penDetectOperation = 1'b1;
		conv(1'b0);
		srcchk(8'h00);
		penDownIn = 1'b1;
		srcchk(8'h08);
		nearObjectIn = 1'b1;
		srcchk(8'h00);
		penDownIn = 1'b0;
		srcchk(8'h44);
		nearObjectIn = 1'b0;
		srcchk(8'h00);
		hostU.wr(ADDR_STATUS, 8'h10);
		check("compRequest", 8'h01, {7'h00, compRequest});
		rdchk(ADDR_STATUS, 8'h10, "status");
		compDoneIn = 1'b1;
		@(negedge sys_clk);
		compDoneIn = 1'b0;
		srcchk(8'h10);
		check("compRequest", 8'h00, {7'h00, compRequest});
		for (int k = 0; k < 2; k++) begin
			bitV = (k == 0) ? 8'h02 : 8'h01;
			therm(k, 1'b1, 1'b1);
			srcchk(bitV);
			therm(k, 1'b0, 1'b0);
			srcchk(bitV);
			therm(k, 1'b0, 1'b1);
			srcchk(8'h00);
			therm(k, 1'b1, 1'b0);
			srcchk(8'h00);
		end
		for (int n = 0; n < 6; n++) begin
			curMask = 8'($urandom);
			hostU.wr(ADDR_IRQ_MASK, curMask);
			rdchk(ADDR_IRQ_MASK, curMask, "mask");
			therm(0, 1'b1, 1'b1);
			srcchk(8'h02);
			therm(0, 1'b1, 1'b0);
			srcchk(8'h00);
		end
		// A second reset must raise the reset flag again and restore the mask
		reset_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		reset_n = 1'b1;
		rdchk(ADDR_STATUS, 8'h40, "status");
		rdchk(ADDR_IRQ_MASK, RST_IRQ_MASK, "mask");
		conclude();
	end
endmodule
